// ---- rtl/config_nv_ctrl.sv ----
// configuration-mode logic: reset pin, spi slave on the control pins,
// customer configuration registers and the commit to the nonvolatile store
// assumes the store itself and the supply monitor sit outside
`timescale 1ns/10ps
module config_nv_ctrl #(
  parameter int WIDTH_SHORT_CYC = cfg_nv_pkg::WIDTH_SHORT_US * cfg_nv_pkg::CLK_KHZ / 1000,
  parameter int WIDTH_LONG_CYC = cfg_nv_pkg::WIDTH_LONG_US * cfg_nv_pkg::CLK_KHZ / 1000,
  parameter int PROG_LIMIT_CYC = cfg_nv_pkg::PROG_LIMIT_MS * cfg_nv_pkg::CLK_KHZ,
  parameter logic [7:0] CRC_INIT = 8'h81,
  parameter logic [7:0] CRC_POLY = 8'h2F
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic supply_ok,
  input wire logic bat_above_thr,
  input wire logic sys_reset_req,
  input wire logic nv_configured,
  input wire logic nv_fault,
  input wire logic [47:0] nv_image,
  input wire logic nv_prog_done,
  input wire logic nv_prog_ok,
  output logic nv_prog_req,
  output logic [47:0] prog_image,
  input wire logic reset_pin_i,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  input wire logic bus_dominant,
  input wire logic txd_sdi,
  input wire logic en_sck,
  input wire logic standby_ctrl_pin,
  output logic rxd_sdo_o,
  output logic rxd_sdo_oe,
  output logic config_mode,
  output logic regulator_on,
  output cfg_nv_pkg::cfg_s cfg
);
  // ****************************************************************
  // functions
  // ****************************************************************
  // one crc byte step, msb first
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // ****************************************************************
  // input synchronisers
  // ****************************************************************
  cfg_nv_pkg::pins_s in_w;
  cfg_nv_pkg::pins_s s1_q, s2_q, s3_q, f_q;
  assign in_w = '{sck: en_sck, sdi: txd_sdi, csn: standby_ctrl_pin, rstn: reset_pin_i, bus_dom: bus_dominant};

  // three stages per pin, filtered value follows once stages two and three agree
  for (genvar i = 0; i < $bits(cfg_nv_pkg::pins_s); i++) begin : g_sync
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        s1_q[i] <= cfg_nv_pkg::PINS_IDLE[i];
        s2_q[i] <= cfg_nv_pkg::PINS_IDLE[i];
        s3_q[i] <= cfg_nv_pkg::PINS_IDLE[i];
        f_q[i] <= cfg_nv_pkg::PINS_IDLE[i];
      end else begin
        s1_q[i] <= in_w[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          f_q[i] <= s3_q[i];
        end
      end
    end
  end

  // ****************************************************************
  // state
  // ****************************************************************
  cfg_nv_pkg::mode_e mode_q, mode_d;
  logic [7:0] cfg_q [cfg_nv_pkg::NUM_CFG];
  logic [47:0] cfg_flat_w;
  logic [7:0] crc_q;
  logic [cfg_nv_pkg::TMR_W-1:0] timer_q, width_tgt_w;
  logic rel_q, boot_q, restore_q, configured_q, err_q;
  logic [cfg_nv_pkg::CNT_W-1:0] wcnt_q;
  logic sck_prev_q, sdo_q, rd_q;
  logic [4:0] bit_cnt_q;
  logic [7:0] rx_q, tx_q, rx_w, status_w, crc_calc_w;
  logic [6:0] addr_q, wr_addr_w, rd_addr_w;
  logic fall_w, rise_w, in_frame_w, byte_done_w, wr_en_w, crc_wr_w, crc_ok_w;
  logic ext_rst_w, width_done_w, leave_w, go_config_w, cnt_full_w, prog_fail_w;

  // flat image of the customer registers, lowest address in the top byte
  for (genvar k = 0; k < cfg_nv_pkg::NUM_CFG; k++) begin : g_flat
    assign cfg_flat_w[47-8*k -: 8] = cfg_q[k];
  end

  // register read mux, used for the first and second data byte
  function automatic logic [7:0] reg_read(input logic [6:0] a, input logic [47:0] img,
                                          input logic [7:0] crc, input logic [7:0] st);
    logic [6:0] idx;
    idx = a - cfg_nv_pkg::ADDR_SYS;
    if (a >= cfg_nv_pkg::ADDR_SYS && a <= cfg_nv_pkg::ADDR_OUT) begin
      return img[47-8*idx -: 8];
    end else if (a == cfg_nv_pkg::ADDR_CRC) begin
      return crc;
    end else if (a == cfg_nv_pkg::ADDR_STAT) begin
      return st;
    end
    return cfg_nv_pkg::ZERO_BYTE;
  endfunction

  // ****************************************************************
  // crc over registers and fixed bytes
  // ****************************************************************
  always_comb begin
    crc_calc_w = CRC_INIT;
    for (int k = 0; k < cfg_nv_pkg::NUM_CFG; k++) begin
      crc_calc_w = crc_step(crc_calc_w, cfg_q[k]);
    end
    crc_calc_w = crc_step(crc_calc_w, cfg_nv_pkg::FIX_BYTE_20);
    crc_calc_w = crc_step(crc_calc_w, cfg_nv_pkg::FIX_BYTE_21);
  end

  // ****************************************************************
  // spi decode
  // ****************************************************************
  assign fall_w = sck_prev_q & ~f_q.sck;
  assign rise_w = ~sck_prev_q & f_q.sck;
  assign in_frame_w = (mode_q == cfg_nv_pkg::MODE_CONFIG) & ~f_q.csn;
  assign rx_w = {rx_q[6:0], f_q.sdi};
  assign byte_done_w = in_frame_w & fall_w & (bit_cnt_q < cfg_nv_pkg::FRAME_END) &
                       (bit_cnt_q[2:0] == cfg_nv_pkg::BYTE_LAST);
  assign wr_addr_w = (bit_cnt_q == cfg_nv_pkg::LAST_BIT_B1) ? addr_q : addr_q + 7'd1;
  assign rd_addr_w = (bit_cnt_q == cfg_nv_pkg::LAST_BIT_B0) ? rx_w[6:0] : addr_q + 7'd1;
  assign wr_en_w = byte_done_w & ~rd_q & (bit_cnt_q != cfg_nv_pkg::LAST_BIT_B0);
  assign crc_wr_w = wr_en_w & (wr_addr_w == cfg_nv_pkg::ADDR_CRC);
  assign crc_ok_w = rx_w == crc_calc_w;

  // status word: write access, error, write counter
  assign cnt_full_w = &wcnt_q;
  always_comb begin
    status_w = cfg_nv_pkg::ZERO_BYTE;
    status_w[cfg_nv_pkg::ST_WREN] = config_mode & ~cnt_full_w;
    status_w[cfg_nv_pkg::ST_ERR] = err_q;
    status_w[cfg_nv_pkg::ST_CNT_LO +: cfg_nv_pkg::CNT_W] = wcnt_q;
  end

  // shift engine: sample on falling edge, present next bit on rising edge
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sck_prev_q <= 1'b0;
      bit_cnt_q <= 5'd0;
      rx_q <= 8'h00;
      tx_q <= 8'h00;
      sdo_q <= 1'b0;
      addr_q <= 7'h00;
      rd_q <= 1'b0;
    end else begin
      sck_prev_q <= f_q.sck;
      if (!in_frame_w) begin
        bit_cnt_q <= 5'd0;
        tx_q <= 8'h00;
        sdo_q <= 1'b0;
      end else if (fall_w && bit_cnt_q < cfg_nv_pkg::FRAME_END) begin
        rx_q <= rx_w;
        bit_cnt_q <= bit_cnt_q + 5'd1;
        if (bit_cnt_q == cfg_nv_pkg::LAST_BIT_B0) begin
          addr_q <= rx_w[6:0];
          rd_q <= rx_w[cfg_nv_pkg::RW_BIT];
        end
        if (byte_done_w && bit_cnt_q != cfg_nv_pkg::LAST_BIT_B2) begin
          tx_q <= reg_read(rd_addr_w, cfg_flat_w, crc_q, status_w);
        end
      end else if (rise_w) begin
        sdo_q <= tx_q[7];
        tx_q <= {tx_q[6:0], 1'b0};
      end
    end
  end

  // ****************************************************************
  // mode sequencing
  // ****************************************************************
  assign ext_rst_w = ~f_q.rstn;
  assign width_tgt_w = cfg_q[0][cfg_nv_pkg::SYS_SHORT] ? cfg_nv_pkg::TMR_W'(WIDTH_SHORT_CYC - 1) :
                       cfg_nv_pkg::TMR_W'(WIDTH_LONG_CYC - 1);
  assign width_done_w = supply_ok & (timer_q == width_tgt_w);
  assign leave_w = rel_q & f_q.rstn;
  // unconfigured, faulted or restoring parts go to config; an unconfigured boot without restore waits for the battery
  assign go_config_w = boot_q ? (restore_q | nv_fault | ~nv_configured) : ~configured_q;
  assign prog_fail_w = (nv_prog_done & ~nv_prog_ok) |
                       (timer_q == cfg_nv_pkg::TMR_W'(PROG_LIMIT_CYC - 1));

  // next mode
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      cfg_nv_pkg::MODE_RESET: begin
        if (leave_w && !(boot_q && !restore_q && !nv_configured && !bat_above_thr)) begin
          mode_d = go_config_w ? cfg_nv_pkg::MODE_CONFIG : cfg_nv_pkg::MODE_RUN;
        end
      end
      cfg_nv_pkg::MODE_CONFIG: begin
        if (ext_rst_w || sys_reset_req) begin
          mode_d = cfg_nv_pkg::MODE_RESET;
        end else if (crc_wr_w && crc_ok_w) begin
          mode_d = cfg_nv_pkg::MODE_PROGRAM;
        end
      end
      cfg_nv_pkg::MODE_PROGRAM: begin
        if (ext_rst_w || (nv_prog_done && nv_prog_ok)) begin
          mode_d = cfg_nv_pkg::MODE_RESET;
        end else if (prog_fail_w) begin
          mode_d = cfg_nv_pkg::MODE_CONFIG;
        end
      end
      cfg_nv_pkg::MODE_RUN: begin
        if (ext_rst_w || sys_reset_req) begin
          mode_d = cfg_nv_pkg::MODE_RESET;
        end
      end
      default: mode_d = cfg_nv_pkg::MODE_RESET;
    endcase
  end

  // mode, pulse timer and boot flags
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode_q <= cfg_nv_pkg::MODE_RESET;
      timer_q <= '0;
      rel_q <= 1'b0;
      boot_q <= 1'b1;
      restore_q <= 1'b0;
      configured_q <= 1'b0;
    end else begin
      mode_q <= mode_d;
      if (mode_d != mode_q) begin
        timer_q <= '0;
        rel_q <= 1'b0;
      end else if (mode_q == cfg_nv_pkg::MODE_RESET) begin
        if (!supply_ok && !rel_q) begin
          timer_q <= '0;
        end else if (width_done_w) begin
          rel_q <= 1'b1;
        end else if (!rel_q) begin
          timer_q <= timer_q + 1'b1;
        end
        // pin still held low from outside with the bus dominant after our pulse
        if (boot_q && rel_q && ext_rst_w && f_q.bus_dom) begin
          restore_q <= 1'b1;
        end
      end else if (mode_q == cfg_nv_pkg::MODE_PROGRAM) begin
        timer_q <= timer_q + 1'b1;
      end
      if (mode_q == cfg_nv_pkg::MODE_RESET && mode_d != mode_q) begin
        boot_q <= 1'b0;
        if (boot_q) begin
          configured_q <= nv_configured & ~nv_fault & ~restore_q;
        end
      end
      if (mode_q == cfg_nv_pkg::MODE_PROGRAM && nv_prog_done && nv_prog_ok) begin
        configured_q <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // registers, error flag and write counter
  // ****************************************************************
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int k = 0; k < cfg_nv_pkg::NUM_CFG; k++) begin
        cfg_q[k] <= cfg_nv_pkg::CFG_DEFAULTS[47-8*k -: 8];
      end
      crc_q <= 8'h00;
      err_q <= 1'b0;
      wcnt_q <= '0;
    end else begin
      if (mode_q == cfg_nv_pkg::MODE_RESET && mode_d != mode_q && boot_q) begin
        for (int k = 0; k < cfg_nv_pkg::NUM_CFG; k++) begin
          cfg_q[k] <= (restore_q || nv_fault || !nv_configured) ?
                      cfg_nv_pkg::CFG_DEFAULTS[47-8*k -: 8] : nv_image[47-8*k -: 8];
        end
        if (!restore_q && nv_configured && nv_fault) begin
          err_q <= 1'b1;
        end
      end else if (wr_en_w) begin
        for (int k = 0; k < cfg_nv_pkg::NUM_CFG; k++) begin
          if (wr_addr_w == cfg_nv_pkg::ADDR_SYS + 7'(k)) begin
            cfg_q[k] <= rx_w;
          end
        end
        if (crc_wr_w) begin
          crc_q <= rx_w;
        end
      end
      if ((crc_wr_w && !crc_ok_w) || (mode_q == cfg_nv_pkg::MODE_PROGRAM && prog_fail_w)) begin
        err_q <= 1'b1;
        if (!cnt_full_w) begin
          wcnt_q <= wcnt_q + 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe = (mode_q == cfg_nv_pkg::MODE_RESET) & ~rel_q;
  assign config_mode = mode_q == cfg_nv_pkg::MODE_CONFIG;
  assign regulator_on = 1'b1;
  assign rxd_sdo_oe = config_mode;
  assign rxd_sdo_o = f_q.csn ? 1'b0 : sdo_q;
  assign nv_prog_req = mode_q == cfg_nv_pkg::MODE_PROGRAM;
  assign prog_image = cfg_flat_w;

  // decoded fields for the rest of the chip
  assign cfg.reset_short = cfg_q[0][cfg_nv_pkg::SYS_SHORT];
  assign cfg.sleep_disable = cfg_q[0][cfg_nv_pkg::SYS_NOSLEEP];
  assign cfg.local_wake_pin_1_rise = cfg_q[1][cfg_nv_pkg::WK_W1R];
  assign cfg.local_wake_pin_1_fall = cfg_q[1][cfg_nv_pkg::WK_W1F];
  assign cfg.local_wake_pin_2_rise = cfg_q[1][cfg_nv_pkg::WK_W2R];
  assign cfg.local_wake_pin_2_fall = cfg_q[1][cfg_nv_pkg::WK_W2F];
  assign cfg.bus_wake_en = cfg_q[1][cfg_nv_pkg::WK_BUS];
  assign cfg.uv_detect_off = cfg_q[2][cfg_nv_pkg::REG_UVOFF];
  assign cfg.xcvr_off = cfg_q[3][cfg_nv_pkg::XC_OFF];
  assign cfg.high_speed = cfg_q[3][cfg_nv_pkg::XC_HS];
  assign cfg.txd_timeout_off = cfg_q[3][cfg_nv_pkg::XC_TOOFF];
  assign cfg.wd_mode = cfg_q[4][cfg_nv_pkg::WD_MODE_LO +: 2];
  assign cfg.wd_auto = cfg_q[4][cfg_nv_pkg::WD_AUTO];
  assign cfg.wd_sdm = cfg_q[4][cfg_nv_pkg::WD_SDM];
  assign cfg.wd_period = cfg_q[4][cfg_nv_pkg::WD_PER_LO +: 2];
  assign cfg.out_func = cfg_q[5][cfg_nv_pkg::OUT_FUNC_LO +: 3];
  assign cfg.out_invert = cfg_q[5][cfg_nv_pkg::OUT_INV];
  assign cfg.cyc_period_long = cfg_q[5][cfg_nv_pkg::OUT_PER];
  assign cfg.settle_long = cfg_q[5][cfg_nv_pkg::OUT_SETTLE];

  // ****************************************************************
  // assertions
  // ****************************************************************
  a_sdo_idle_low: assert property (@(posedge ref_clk) disable iff (rst)
    config_mode && f_q.csn |-> rxd_sdo_oe && !rxd_sdo_o) else $error("sdo not low while deselected");
  a_config_release: assert property (@(posedge ref_clk) disable iff (rst)
    config_mode |-> !reset_pin_oe) else $error("reset pin driven in config");
  a_ext_reset: assert property (@(posedge ref_clk) disable iff (rst)
    mode_q == cfg_nv_pkg::MODE_RUN && !f_q.rstn |=> mode_q == cfg_nv_pkg::MODE_RESET)
    else $error("outside reset ignored");
  a_width_release: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(reset_pin_oe) && mode_q == cfg_nv_pkg::MODE_RESET |-> $past(timer_q) == $past(width_tgt_w))
    else $error("reset pulse width wrong");
  a_no_supply_hold: assert property (@(posedge ref_clk) disable iff (rst)
    mode_q == cfg_nv_pkg::MODE_RESET && !supply_ok && !rel_q |=> reset_pin_oe)
    else $error("reset released without supply");
  a_crc_bad_err: assert property (@(posedge ref_clk) disable iff (rst)
    crc_wr_w && !crc_ok_w && !cnt_full_w |=> err_q && wcnt_q == $past(wcnt_q) + 1'b1 &&
    mode_q == cfg_nv_pkg::MODE_CONFIG) else $error("crc mismatch not recorded");
  a_crc_good_go: assert property (@(posedge ref_clk) disable iff (rst)
    config_mode && crc_wr_w && crc_ok_w && f_q.rstn && !sys_reset_req |=> nv_prog_req [*2])
    else $error("commit not started");
  a_done_resets: assert property (@(posedge ref_clk) disable iff (rst)
    nv_prog_req && nv_prog_done && nv_prog_ok |=> reset_pin_oe && configured_q)
    else $error("no system reset after commit");
  a_reg_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr_en_w && wr_addr_w == cfg_nv_pkg::ADDR_REG |=> cfg_q[2] == $past(rx_w))
    else $error("register write lost");
  a_sdo_shift: assert property (@(posedge ref_clk) disable iff (rst)
    in_frame_w && rise_w |=> sdo_q == $past(tx_q[7])) else $error("sdo not shifted on rise");
endmodule

// ---- rtl/cfg_nv_pkg.sv ----
// constants, types and field layouts of the configuration-mode store logic
// assumes a 10 MHz reference clock; shared by the block and its bench
package cfg_nv_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [6:0] ADDR_SYS = 7'h10;
  localparam logic [6:0] ADDR_WAKE = 7'h11;
  localparam logic [6:0] ADDR_REG = 7'h12;
  localparam logic [6:0] ADDR_XCVR = 7'h13;
  localparam logic [6:0] ADDR_WD = 7'h14;
  localparam logic [6:0] ADDR_OUT = 7'h15;
  localparam logic [6:0] ADDR_CRC = 7'h30;
  localparam logic [6:0] ADDR_STAT = 7'h31;
  localparam int NUM_CFG = 6;
  localparam logic [7:0] FIX_BYTE_20 = 8'h00;
  localparam logic [7:0] FIX_BYTE_21 = 8'h01;
  // factory defaults of the customer registers, lowest address first
  localparam logic [47:0] CFG_DEFAULTS = 48'h00_1F_00_00_00_03;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int SYS_SHORT = 0, SYS_NOSLEEP = 1;
  localparam int WK_W1R = 0, WK_W1F = 1, WK_W2R = 2, WK_W2F = 3, WK_BUS = 4;
  localparam int REG_UVOFF = 0;
  localparam int XC_OFF = 0, XC_HS = 1, XC_TOOFF = 2;
  localparam int WD_MODE_LO = 0, WD_AUTO = 2, WD_SDM = 3, WD_PER_LO = 4;
  localparam int OUT_FUNC_LO = 0, OUT_INV = 3, OUT_PER = 4, OUT_SETTLE = 5;
  localparam int ST_WREN = 0, ST_ERR = 1, ST_CNT_LO = 4;
  localparam int CNT_W = 4;

  // ****************************************************************
  // spi framing
  // ****************************************************************
  localparam int RW_BIT = 7;
  localparam logic [4:0] LAST_BIT_B0 = 5'd7;
  localparam logic [4:0] LAST_BIT_B1 = 5'd15;
  localparam logic [4:0] LAST_BIT_B2 = 5'd23;
  localparam logic [4:0] FRAME_END = 5'd24;
  localparam logic [2:0] BYTE_LAST = 3'd7;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int CLK_KHZ = 10000;
  localparam int WIDTH_SHORT_US = 700;
  localparam int WIDTH_LONG_US = 4000;
  localparam int PROG_LIMIT_MS = 80;
  localparam int TMR_W = 20;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_RESET = 2'b00,
    MODE_CONFIG = 2'b01,
    MODE_PROGRAM = 2'b11,
    MODE_RUN = 2'b10
  } mode_e;

  typedef struct packed {
    logic sck;
    logic sdi;
    logic csn;
    logic rstn;
    logic bus_dom;
  } pins_s;
  localparam pins_s PINS_IDLE = '{sck: 1'b0, sdi: 1'b0, csn: 1'b1, rstn: 1'b1, bus_dom: 1'b0};

  typedef struct packed {
    logic reset_short;
    logic sleep_disable;
    logic bus_wake_en;
    logic local_wake_pin_1_rise;
    logic local_wake_pin_1_fall;
    logic local_wake_pin_2_rise;
    logic local_wake_pin_2_fall;
    logic uv_detect_off;
    logic xcvr_off;
    logic high_speed;
    logic txd_timeout_off;
    logic [1:0] wd_mode;
    logic wd_auto;
    logic wd_sdm;
    logic [1:0] wd_period;
    logic [2:0] out_func;
    logic out_invert;
    logic cyc_period_long;
    logic settle_long;
  } cfg_s;
endpackage

// ---- tb/spi_host_model.sv ----
// host side of the configuration port: spi master on the control pins
// assumes sdo arrives as the resolved pin level and sck idles low
`timescale 1ns/10ps
module spi_host_model #(
  parameter int HALF_CYC = 50
) (
  input wire logic ref_clk,
  input wire logic sdo,
  output logic sck,
  output logic sdi,
  output logic csn
);
  // ****
  // frame
  // ****
  initial begin
    sck = 1'b0;
    sdi = 1'b0;
    csn = 1'b1;
  end
  // one frame of 16 or 24 bits, msb first; a short frame uses tx[23:8]
  task automatic frame(input logic [23:0] tx, input logic long, output logic [23:0] rx);
    rx = 24'h000000;
    @(posedge ref_clk) #1;
    csn = 1'b0;
    repeat (HALF_CYC) @(posedge ref_clk);
    #1;
    for (int i = 23; i > (long ? -1 : 7); i--) begin
      sck = 1'b1;
      sdi = tx[i];
      repeat (HALF_CYC) @(posedge ref_clk);
      #1;
      rx[i] = sdo;
      sck = 1'b0;
      repeat (HALF_CYC) @(posedge ref_clk);
      #1;
    end
    csn = 1'b1;
    sdi = ~sdi; // line no longer carries data
    repeat (HALF_CYC) @(posedge ref_clk);
    #1;
  endtask
endmodule

// ---- tb/config_nv_ctrl_tb.sv ----
// bench of the configuration-mode store logic
// assumes the host model drives the spi pins; the bench plays the store
`timescale 1ns/10ps
module config_nv_ctrl_tb;
  localparam int WS = 20;
  localparam int WL = 40;
  localparam logic [63:0] CRC_IN = 64'h01_0A_55_06_31_03_00_01;
  logic ref_clk, rst = 1'b1, supply_ok = 1'b0, bat_above_thr = 1'b1, sys_reset_req = 1'b0;
  logic nv_prog_done = 1'b0, nv_prog_ok = 1'b0, host_rst_low = 1'b0, sdo_last = 1'b0;
  logic nv_configured = 1'b0, nv_fault = 1'b0, bus_dominant = 1'b0;
  logic [47:0] nv_image = CRC_IN[63:16], prog_image;
  logic nv_prog_req, reset_pin_o, reset_pin_oe, rxd_sdo_o, rxd_sdo_oe, config_mode, regulator_on;
  logic txd_sdi, en_sck, standby_ctrl_pin;
  logic [23:0] r;
  int errors = 0, n_compared = 0;
  cfg_nv_pkg::cfg_s cfg;
  // ****
  // pins and instances
  // ****
  wire reset_pin_i = ~((reset_pin_oe & ~reset_pin_o) | host_rst_low); // pulled up
  wire sdo_w = rxd_sdo_oe ? rxd_sdo_o : ~sdo_last;
  always @(posedge ref_clk) if (rxd_sdo_oe) sdo_last <= rxd_sdo_o;
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  config_nv_ctrl #(.WIDTH_SHORT_CYC(WS), .WIDTH_LONG_CYC(WL), .PROG_LIMIT_CYC(200)) u_dut (
    .ref_clk, .rst, .supply_ok, .bat_above_thr, .sys_reset_req, .nv_configured, .nv_fault,
    .nv_image, .nv_prog_done, .nv_prog_ok, .nv_prog_req, .prog_image, .reset_pin_i,
    .reset_pin_o, .reset_pin_oe, .bus_dominant, .txd_sdi, .en_sck, .standby_ctrl_pin,
    .rxd_sdo_o, .rxd_sdo_oe, .config_mode, .regulator_on, .cfg);
  spi_host_model u_host (.ref_clk, .sdo(sdo_w), .sck(en_sck), .sdi(txd_sdi), .csn(standby_ctrl_pin));
  // ****
  // tasks
  // ****
  task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] d, input logic long);
    logic [23:0] x;
    u_host.frame({1'b0, a, d}, long, x);
  endtask
  task automatic rd(input logic [6:0] a, input logic long);
    u_host.frame({1'b1, a, 16'h0000}, long, r);
  endtask
  task automatic wait_release();
    for (int i = 0; i < 60 && reset_pin_oe !== 1'b0; i++) cyc(1);
    chk("pin released in time", 24'h0, reset_pin_oe);
    cyc(8);
  endtask
  function automatic logic [7:0] crc8(input logic [63:0] b);
    logic [7:0] c;
    c = 8'h81;
    for (int i = 63; i >= 0; i--) c = (c[7] ^ b[i]) ? {c[6:0], 1'b0} ^ 8'h2F : {c[6:0], 1'b0};
    return c;
  endfunction
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // ****
  // tests
  // ****
  initial begin
    for (int c = 0; c < 60000; c++) @(posedge ref_clk);
    errors++;
    close_out();
  end
  initial begin
    cyc(8);
    rst = 1'b0;
    cyc(10);
    chk("pin before supply", 24'h1, reset_pin_oe);
    supply_ok = 1'b1;
    cyc(WL - 2);
    chk("pin long width", 24'h1, reset_pin_oe);
    for (int i = 0; i < 40 && config_mode !== 1'b1; i++) cyc(1);
    chk("config entered", 24'h1, config_mode);
    chk("pin released", 24'h0, reset_pin_oe);
    chk("regulator", 24'h1, regulator_on);
    chk("sdo deselected", 24'h2, {rxd_sdo_oe, rxd_sdo_o});
    chk("wake defaults", 24'h1F, {cfg.bus_wake_en, cfg.local_wake_pin_2_fall, cfg.local_wake_pin_2_rise, cfg.local_wake_pin_1_fall, cfg.local_wake_pin_1_rise});
    $display("test boot done");
    wr(7'h12, 16'h5500, 1'b0);
    chk("uv off", 24'h1, cfg.uv_detect_off);
    rd(7'h12, 1'b0);
    chk("read 12h", 24'h55, r[15:8]);
    wr(7'h10, 16'h010A, 1'b1);
    wr(7'h13, 16'h0600, 1'b0);
    wr(7'h14, 16'h3103, 1'b1);
    rd(7'h10, 1'b1);
    chk("read 10h 11h", 24'h010A, r[15:0]);
    chk("sys wake", 24'h7, {cfg.reset_short, cfg.local_wake_pin_1_fall, cfg.local_wake_pin_2_fall});
    chk("xcvr", 24'h6, {cfg.txd_timeout_off, cfg.high_speed, cfg.xcvr_off});
    chk("wdog out", 24'h3D, {cfg.out_func, cfg.wd_period, cfg.wd_mode});
    wr(7'h31, 16'hFF00, 1'b0);
    rd(7'h31, 1'b0);
    chk("status idle", 24'h01, r[15:8]);
    rd(7'h40, 1'b0);
    chk("unmapped", 24'h00, r[15:8]);
    $display("test registers done");
    wr(7'h30, {~crc8(CRC_IN), 8'h00}, 1'b0);
    chk("no program", 24'h0, nv_prog_req);
    rd(7'h31, 1'b0);
    chk("status error", 24'h13, r[15:8]);
    // store never answers: host waits, sees no reset and re-reads the status
    wr(7'h30, {crc8(CRC_IN), 8'h00}, 1'b0);
    cyc(150);
    chk("no reset, back to config", 24'h1, config_mode);
    rd(7'h31, 1'b0);
    chk("status timeout", 24'h23, r[15:8]);
    wr(7'h30, {crc8(CRC_IN), 8'h00}, 1'b0);
    chk("program", 24'h1, nv_prog_req);
    nv_prog_done = 1'b1;
    nv_prog_ok = 1'b1;
    cyc(1);
    nv_prog_done = 1'b0;
    cyc(3);
    chk("commit reset", 24'h2, {reset_pin_oe, config_mode});
    cyc(WS - 6);
    chk("short width", 24'h1, reset_pin_oe);
    wait_release();
    chk("run after commit", 24'h0, {reset_pin_oe, config_mode});
    $display("test commit done");
    host_rst_low = 1'b1;
    cyc(8);
    host_rst_low = 1'b0;
    chk("outside reset", 24'h1, reset_pin_oe);
    wait_release();
    sys_reset_req = 1'b1;
    cyc(1);
    sys_reset_req = 1'b0;
    cyc(6);
    chk("request reset", 24'h1, reset_pin_oe);
    wait_release();
    $display("test resets done");
    // second power-on with a store fault: config mode with the error flag
    rst = 1'b1;
    nv_configured = 1'b1;
    nv_fault = 1'b1;
    cyc(2);
    rst = 1'b0;
    wait_release();
    chk("fault to config", 24'h1, config_mode);
    chk("fault defaults", cfg_nv_pkg::CFG_DEFAULTS, prog_image);
    rd(7'h31, 1'b0);
    chk("fault status", 24'h03, r[15:8]);
    // factory restore: pin held low and bus dominant past our pulse
    rst = 1'b1;
    nv_fault = 1'b0;
    host_rst_low = 1'b1;
    bus_dominant = 1'b1;
    cyc(2);
    rst = 1'b0;
    cyc(WL + 10);
    host_rst_low = 1'b0;
    bus_dominant = 1'b0;
    cyc(8);
    chk("restore config", 24'h1, config_mode);
    chk("restore defaults", cfg_nv_pkg::CFG_DEFAULTS, prog_image);
    // configured part boots to run with the stored image
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    wait_release();
    chk("configured run", 24'h0, config_mode);
    chk("image loaded", nv_image, prog_image);
    // unconfigured part waits for the battery threshold
    rst = 1'b1;
    nv_configured = 1'b0;
    bat_above_thr = 1'b0;
    cyc(2);
    rst = 1'b0;
    wait_release();
    chk("low battery waits", 24'h0, config_mode);
    bat_above_thr = 1'b1;
    cyc(2);
    chk("battery config", 24'h1, config_mode);
    $display("test boot paths done");
    close_out();
  end
endmodule
